// ===== src/adccr_regs.sv
// What this block does
// - Bits at 04h disable channel high-pass filters; reset zero, all on.
// - Power-down bit 5 at 06h shuts the bandgap; clearing restores it.
// - Power-down bit 4 stops the oscillator core clock to internal logic.
// - Bit 4 also blocks an external master clock from internal logic.
// - Bits 3..0 stop pair clocks; that pair's output sends zeroes.
// - Power-down register resets to zero; bits 7 and 6 are reserved.
// - Bits at 08h mute channels, forcing their serial output to zeroes.
// - Mute register resets to zero, nothing muted.
// - Bits 3..0 at 0Ah tri-state one serial output pin each; 7..4 unused.
// - Tri-state register resets to zero, all four pins driving.
// - Registers govern only while port enable is set; else the strap sets high-pass, rest at defaults.
`timescale 1ns/100ps
`default_nettype none

module adccr_regs #(
    parameter int CHANNELS = 8,
    parameter int PAIRS    = 4
) (
    // Clock and reset
    input  wire logic                CORE_CLK,
    input  wire logic                RST_N,
    // Control-port byte engine
    input  wire logic                MAP_LOAD,
    input  wire logic [7:0]          MAP_BYTE,
    input  wire logic                WR_STB,
    input  wire logic [7:0]          WR_DATA,
    input  wire logic                RD_STB,
    output logic      [7:0]          RD_DATA,
    // Global mode
    input  wire logic                CONTROL_PORT_ENABLE,
    input  wire logic                STRAP_HIGHPASS_OFF,
    // Analog and clock controls
    output logic      [CHANNELS-1:0] HIGHPASS_ACTIVE,
    output logic                     BANDGAP_ON,
    output logic                     OSC_CORE_RUN,
    output logic                     MASTER_CLK_PASS,
    output logic      [PAIRS-1:0]    PAIR_CLK_RUN,
    // Serial audio out, one pin per channel pair
    input  wire logic [PAIRS-1:0]    SER_BIT_IN,
    input  wire logic                SER_SLOT_RIGHT,
    output logic      [PAIRS-1:0]    SERIAL_AUDIO_OUT_O,
    output logic      [PAIRS-1:0]    SERIAL_AUDIO_OUT_OE
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0]                      highpass_disable_r;
    logic [adccr_pkg::POWER_DOWN_WIDTH-1:0] power_down_control_r;
    logic [7:0]                      channel_mute_r;
    logic [adccr_pkg::TRISTATE_WIDTH-1:0]   serial_out_tristate_r;
    logic [adccr_pkg::MAP_ADDR_WIDTH-1:0]   map_addr_r;
    logic                            map_auto_inc_r;
    logic                            strap_meta_r;
    logic                            strap_sync_r;

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    function automatic logic [7:0] read_value(
        input logic [adccr_pkg::MAP_ADDR_WIDTH-1:0] addr
    );
        logic [7:0] value;
        value = adccr_pkg::READ_ZERO;
        case (addr)
            adccr_pkg::HIGHPASS_DISABLE_ADDR: begin
                value = highpass_disable_r;
            end
            adccr_pkg::POWER_DOWN_CONTROL_ADDR: begin
                value = {2'h0, power_down_control_r};
            end
            adccr_pkg::CHANNEL_MUTE_ADDR: begin
                value = channel_mute_r;
            end
            adccr_pkg::SERIAL_OUT_TRISTATE_ADDR: begin
                value = {4'h0, serial_out_tristate_r};
            end
            default: begin
                value = adccr_pkg::READ_ZERO;
            end
        endcase
        return value;
    endfunction

    // ------------------------------------------------------------
    // Address pointer
    // ------------------------------------------------------------
    // A pointer load in the same cycle as a data strobe wins
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            map_addr_r     <= '0;
            map_auto_inc_r <= 1'b0;
        end else if (MAP_LOAD) begin
            map_addr_r     <=
                MAP_BYTE[adccr_pkg::MAP_ADDR_WIDTH-1:0];
            map_auto_inc_r <= MAP_BYTE[adccr_pkg::MAP_AUTO_INC_BIT];
        end else if ((WR_STB || RD_STB) && map_auto_inc_r) begin
            map_addr_r     <= map_addr_r + 7'h01;
        end
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    logic wr_go;
    assign wr_go = WR_STB && !MAP_LOAD;

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            highpass_disable_r <= adccr_pkg::HIGHPASS_DISABLE_RST;
        end else if (wr_go &&
                     map_addr_r == adccr_pkg::HIGHPASS_DISABLE_ADDR) begin
            highpass_disable_r <= WR_DATA;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            power_down_control_r <=
                adccr_pkg::POWER_DOWN_CONTROL_RST;
        end else if (wr_go &&
                     map_addr_r == adccr_pkg::POWER_DOWN_CONTROL_ADDR) begin
            // Reserved bits 7:6 have no storage
            power_down_control_r <=
                WR_DATA[adccr_pkg::POWER_DOWN_WIDTH-1:0];
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            channel_mute_r <= adccr_pkg::CHANNEL_MUTE_RST;
        end else if (wr_go &&
                     map_addr_r == adccr_pkg::CHANNEL_MUTE_ADDR) begin
            channel_mute_r <= WR_DATA;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            serial_out_tristate_r <=
                adccr_pkg::SERIAL_OUT_TRISTATE_RST;
        end else if (wr_go &&
                     map_addr_r == adccr_pkg::SERIAL_OUT_TRISTATE_ADDR) begin
            serial_out_tristate_r <=
                WR_DATA[adccr_pkg::TRISTATE_WIDTH-1:0];
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            RD_DATA <= adccr_pkg::READ_ZERO;
        end else if (RD_STB && !MAP_LOAD) begin
            RD_DATA <= read_value(map_addr_r);
        end
    end

    // ------------------------------------------------------------
    // Strap synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            strap_meta_r <= 1'b0;
            strap_sync_r <= 1'b0;
        end else begin
            strap_meta_r <= STRAP_HIGHPASS_OFF;
            strap_sync_r <= strap_meta_r;
        end
    end

    // ------------------------------------------------------------
    // Effective controls
    // ------------------------------------------------------------
    // Stand-alone mode: everything powered, nothing muted, pins driven
    logic [7:0]       hp_off_eff;
    logic [5:0]       pwr_off_eff;
    logic [7:0]       mute_eff;
    logic [PAIRS-1:0] tri_eff;
    logic [PAIRS-1:0] pair_off;

    always_comb begin
        if (CONTROL_PORT_ENABLE) begin
            hp_off_eff = highpass_disable_r;
            pwr_off_eff = power_down_control_r;
            mute_eff   = channel_mute_r;
            tri_eff    = serial_out_tristate_r;
        end else begin
            hp_off_eff = {8{strap_sync_r}};
            pwr_off_eff = 6'h00;
            mute_eff   = 8'h00;
            tri_eff    = '0;
        end
    end

    assign pair_off = pwr_off_eff[adccr_pkg::PAIR_OFF_LSB +: PAIRS];

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            HIGHPASS_ACTIVE <= '1;
            BANDGAP_ON      <= 1'b1;
            OSC_CORE_RUN    <= 1'b1;
            MASTER_CLK_PASS <= 1'b1;
            PAIR_CLK_RUN    <= '1;
        end else begin
            HIGHPASS_ACTIVE <= ~hp_off_eff[CHANNELS-1:0];
            BANDGAP_ON      <=
                ~pwr_off_eff[adccr_pkg::BANDGAP_OFF_BIT];
            OSC_CORE_RUN    <=
                ~pwr_off_eff[adccr_pkg::OSCILLATOR_OFF_BIT];
            MASTER_CLK_PASS <=
                ~pwr_off_eff[adccr_pkg::OSCILLATOR_OFF_BIT];
            PAIR_CLK_RUN    <= ~pair_off;
        end
    end

    // ------------------------------------------------------------
    // Serial output gating
    // ------------------------------------------------------------
    // Pin k carries channel 2k in the left slot, 2k+1 in the right slot
    logic [PAIRS-1:0] slot_zero;

    always_comb begin
        for (int k = 0; k < PAIRS; k++) begin
            slot_zero[k] = pair_off[k] ||
                           (SER_SLOT_RIGHT ? mute_eff[2*k+1]
                                           : mute_eff[2*k]);
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            SERIAL_AUDIO_OUT_O  <= '0;
            SERIAL_AUDIO_OUT_OE <= '1;
        end else begin
            SERIAL_AUDIO_OUT_O  <=
                SER_BIT_IN & ~slot_zero;
            SERIAL_AUDIO_OUT_OE <= ~tri_eff;
        end
    end

endmodule

`default_nettype wire

// ===== src/adccr_pkg.sv
package adccr_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [6:0] HIGHPASS_DISABLE_ADDR    = 7'h04;
    localparam logic [6:0] RESERVED_A_ADDR          = 7'h05;
    localparam logic [6:0] POWER_DOWN_CONTROL_ADDR  = 7'h06;
    localparam logic [6:0] RESERVED_B_ADDR          = 7'h07;
    localparam logic [6:0] CHANNEL_MUTE_ADDR        = 7'h08;
    localparam logic [6:0] RESERVED_C_ADDR          = 7'h09;
    localparam logic [6:0] SERIAL_OUT_TRISTATE_ADDR = 7'h0a;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] HIGHPASS_DISABLE_RST    = 8'h00;
    localparam logic [5:0] POWER_DOWN_CONTROL_RST  = 6'h00;
    localparam logic [7:0] CHANNEL_MUTE_RST        = 8'h00;
    localparam logic [3:0] SERIAL_OUT_TRISTATE_RST = 4'h0;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BANDGAP_OFF_BIT    = 5;
    localparam int OSCILLATOR_OFF_BIT = 4;
    localparam int PAIR_OFF_LSB       = 0;
    localparam int PAIR_OFF_WIDTH     = 4;
    localparam int POWER_DOWN_WIDTH   = 6;
    localparam int TRISTATE_WIDTH     = 4;
    localparam int MAP_AUTO_INC_BIT   = 7;
    localparam int MAP_ADDR_WIDTH     = 7;

    localparam logic [7:0] READ_ZERO = 8'h00;

endpackage

// ===== tb/adccr_regs_chk.sv
`timescale 1ns/100ps
`default_nettype none
module adccr_regs_chk #(
    parameter int CHANNELS = 8,
    parameter int PAIRS    = 4
) (
    // Clock and reset
    input wire logic                CORE_CLK,
    input wire logic                RST_N,
    // Watched ports
    input wire logic                WR_STB,
    input wire logic                RD_STB,
    input wire logic [7:0]          RD_DATA,
    input wire logic                CONTROL_PORT_ENABLE,
    input wire logic [CHANNELS-1:0] HIGHPASS_ACTIVE,
    input wire logic                BANDGAP_ON,
    input wire logic                OSC_CORE_RUN,
    input wire logic                MASTER_CLK_PASS,
    input wire logic [PAIRS-1:0]    PAIR_CLK_RUN,
    input wire logic [PAIRS-1:0]    SER_BIT_IN,
    input wire logic [PAIRS-1:0]    SERIAL_AUDIO_OUT_O,
    input wire logic [PAIRS-1:0]    SERIAL_AUDIO_OUT_OE
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_N);
    property p_sa_power;
        !CONTROL_PORT_ENABLE [*2] |-> BANDGAP_ON && PAIR_CLK_RUN == '1;
    endproperty
    a_sa_power: assert property (p_sa_power)
        else $error("power outputs off in stand-alone mode");
    property p_sa_oe;
        !CONTROL_PORT_ENABLE [*2] |-> SERIAL_AUDIO_OUT_OE == '1;
    endproperty
    a_sa_oe: assert property (p_sa_oe)
        else $error("pin undriven in stand-alone mode");
    property p_sa_hp;
        HIGHPASS_ACTIVE == '0 || HIGHPASS_ACTIVE == '1 || CONTROL_PORT_ENABLE
            || $past(CONTROL_PORT_ENABLE) || $past(CONTROL_PORT_ENABLE, 2);
    endproperty
    a_sa_hp: assert property (p_sa_hp)
        else $error("strap high-pass not common to all channels");
    property p_osc_mclk;
        OSC_CORE_RUN == MASTER_CLK_PASS;
    endproperty
    a_osc_mclk: assert property (p_osc_mclk)
        else $error("master clock gate differs from oscillator run");
    property p_ser_zero;
        (SERIAL_AUDIO_OUT_O & ~$past(SER_BIT_IN)) == '0;
    endproperty
    a_ser_zero: assert property (p_ser_zero)
        else $error("serial output one without a source one");
    property p_pair_zero;
        (SERIAL_AUDIO_OUT_O & ~PAIR_CLK_RUN) == '0;
    endproperty
    a_pair_zero: assert property (p_pair_zero)
        else $error("stopped pair still sends ones");
    property p_oe_cause;
        $changed(SERIAL_AUDIO_OUT_OE) |-> $past(WR_STB, 2)
            || $past(CONTROL_PORT_ENABLE) != $past(CONTROL_PORT_ENABLE, 2);
    endproperty
    a_oe_cause: assert property (p_oe_cause)
        else $error("output enable moved without a write");
    property p_rd_hold;
        $changed(RD_DATA) |-> $past(RD_STB);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read byte moved without a read");
endmodule
bind adccr_regs adccr_regs_chk #(.CHANNELS(CHANNELS), .PAIRS(PAIRS)) i_chk (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .WR_STB(WR_STB), .RD_STB(RD_STB),
    .RD_DATA(RD_DATA), .CONTROL_PORT_ENABLE(CONTROL_PORT_ENABLE),
    .HIGHPASS_ACTIVE(HIGHPASS_ACTIVE), .BANDGAP_ON(BANDGAP_ON),
    .OSC_CORE_RUN(OSC_CORE_RUN), .MASTER_CLK_PASS(MASTER_CLK_PASS),
    .PAIR_CLK_RUN(PAIR_CLK_RUN), .SER_BIT_IN(SER_BIT_IN),
    .SERIAL_AUDIO_OUT_O(SERIAL_AUDIO_OUT_O),
    .SERIAL_AUDIO_OUT_OE(SERIAL_AUDIO_OUT_OE));
`default_nettype wire

// ===== tb/adccr_host.sv
`timescale 1ns/100ps
`default_nettype none
module adccr_host (
    // Clock
    input  wire logic       CORE_CLK,
    // Register byte port
    output logic            MAP_LOAD,
    output logic [7:0]      MAP_BYTE,
    output logic            WR_STB,
    output logic [7:0]      WR_DATA,
    output logic            RD_STB,
    input  wire logic [7:0] RD_DATA
);
    initial begin
        MAP_LOAD = 1'b0;
        MAP_BYTE = 8'h00;
        WR_STB = 1'b0;
        WR_DATA = 8'h00;
        RD_STB = 1'b0;
    end
    // Pointer before data; bit 7 asks for stepping
    task automatic point(input logic [7:0] map);
        @(negedge CORE_CLK);
        MAP_LOAD <= 1'b1;
        MAP_BYTE <= map;
        @(negedge CORE_CLK);
        MAP_LOAD <= 1'b0;
        MAP_BYTE <= ~map;
    endtask
    // Idle data is scrambled so stale bytes never look valid
    task automatic wr(input logic [7:0] d);
        @(negedge CORE_CLK);
        WR_STB <= 1'b1;
        WR_DATA <= d;
        @(negedge CORE_CLK);
        WR_STB <= 1'b0;
        WR_DATA <= ~d;
    endtask
    task automatic rd(output logic [7:0] d);
        @(negedge CORE_CLK);
        RD_STB <= 1'b1;
        @(negedge CORE_CLK);
        RD_STB <= 1'b0;
        @(negedge CORE_CLK);
        d = RD_DATA;
    endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic       clk, rst_n, map_ld, wr_stb, rd_stb, cpe, strap, right;
    logic [7:0] map_b, wr_d, rd_d, hp;
    logic [3:0] pcr, ser_in, ser_o, oe;
    logic       bg, osc, mcp;
    logic [7:0] pwr;
    int         error_cnt, checks_done;
    int         cyc = 0;
    assign pwr = {1'b0, bg, osc, mcp, pcr};
    adccr_regs i_dut (.CORE_CLK(clk), .RST_N(rst_n), .MAP_LOAD(map_ld),
        .MAP_BYTE(map_b), .WR_STB(wr_stb), .WR_DATA(wr_d), .RD_STB(rd_stb),
        .RD_DATA(rd_d), .CONTROL_PORT_ENABLE(cpe), .STRAP_HIGHPASS_OFF(strap),
        .HIGHPASS_ACTIVE(hp), .BANDGAP_ON(bg), .OSC_CORE_RUN(osc),
        .MASTER_CLK_PASS(mcp), .PAIR_CLK_RUN(pcr), .SER_BIT_IN(ser_in),
        .SER_SLOT_RIGHT(right), .SERIAL_AUDIO_OUT_O(ser_o),
        .SERIAL_AUDIO_OUT_OE(oe));
    adccr_host i_host (.CORE_CLK(clk), .MAP_LOAD(map_ld), .MAP_BYTE(map_b),
        .WR_STB(wr_stb), .WR_DATA(wr_d), .RD_STB(rd_stb), .RD_DATA(rd_d));
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic settle();
        repeat (3) @(negedge clk);
    endtask
    // Defaults seen at the outputs and read back through the map
    task automatic t_defaults();
        logic [7:0] v;
        cpe = 1'b1;
        settle();
        check("rst highpass", hp, 8'hff);
        check("rst power", pwr, 8'h7f);
        check("rst enable", oe, 4'hf);
        i_host.point(8'h84);
        for (int i = 0; i < 7; i++) begin
            i_host.rd(v);
            check("rst byte", v, 8'h00);
        end
    endtask
    // Whole map walked with stepping; reserved places read zero
    task automatic t_burst(input logic [7:0] w [7], input logic [7:0] e [7]);
        logic [7:0] v;
        i_host.point(8'h84);
        for (int i = 0; i < 7; i++) i_host.wr(w[i]);
        i_host.point(8'h84);
        for (int i = 0; i < 7; i++) begin
            i_host.rd(v);
            check("map byte", v, e[i]);
        end
    endtask
    task automatic t_controls();
        logic [3:0] keep;
        cpe = 1'b1;
        ser_in = 4'hf;
        right = 1'b0;
        settle();
        check("highpass", hp, 8'ha5);
        check("power", pwr, 8'h03);
        check("enable", oe, 4'h3);
        check("left out", ser_o, 4'h2);
        right = 1'b1;
        settle();
        check("right out", ser_o, 4'h3);
        // Pins 2 and 3 are off; mute 81 silences pin 0 left only
        for (int p = 0; p < 16; p++) begin
            ser_in = 4'(p);
            right = p[0];
            keep = right ? 4'h3 : 4'h2;
            @(negedge clk);
            check("serial out", ser_o, ser_in & keep);
        end
    endtask
    task automatic t_standalone();
        cpe = 1'b0;
        strap = 1'b0;
        repeat (5) @(negedge clk);
        check("sa highpass on", hp, 8'hff);
        strap = 1'b1;
        repeat (5) @(negedge clk);
        check("sa power", pwr, 8'h7f);
        check("sa out", {oe, ser_o}, 8'hff);
        check("sa highpass", hp, 8'h00);
    endtask
    task automatic t_unmapped();
        logic [7:0] v;
        cpe = 1'b1;
        i_host.point(8'h20);
        i_host.wr(8'hff);
        i_host.point(8'h20);
        i_host.rd(v);
        check("unmapped", v, 8'h00);
        i_host.point(8'h08);
        i_host.wr(8'h42);
        i_host.rd(v);
        check("no step a", v, 8'h42);
        i_host.rd(v);
        check("no step b", v, 8'h42);
        i_host.point(8'h06);
        i_host.wr(8'h3f);
        i_host.point(8'h0a);
        i_host.wr(8'h0f);
        settle();
        check("all off", pwr, 8'h00);
        check("all tristate", oe, 4'h0);
        check("pairs silent", ser_o, 4'h0);
        i_host.point(8'h86);
        i_host.wr(8'h00);
        i_host.wr(8'h00);
        i_host.wr(8'h00);
        i_host.wr(8'h00);
        i_host.wr(8'h00);
        settle();
        check("restored power", pwr, 8'h7f);
        check("restored enable", oe, 4'hf);
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            error_cnt++;
            wrap_up();
        end
    end
    initial begin
        {rst_n, cpe, strap, right, ser_in, error_cnt, checks_done} = '0;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        t_defaults();
        t_burst('{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00},
                '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        t_burst('{8'h5a, 8'hff, 8'h3c, 8'hff, 8'h81, 8'hff, 8'hfc},
                '{8'h5a, 8'h00, 8'h3c, 8'h00, 8'h81, 8'h00, 8'h0c});
        t_controls();
        t_standalone();
        // Mid-run reset must bring every register back to its default
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        t_defaults();
        t_unmapped();
        wrap_up();
    end
endmodule
`default_nettype wire
